// file: common/srp_link_if.sv
// Pin-level link between host and serial register port
`timescale 1ns/1ps
`default_nettype none
interface srp_link_if;
  logic sclk;
  logic cs_n;
  logic host_dat_o;
  logic host_dat_oe;
  logic dev_dat_o;
  logic dev_dat_oe;
  logic dev_sdo_o;
  logic dev_sdo_oe;
  logic dat;
  logic sdo;
  // Pulled-up shared data line and data-out pin
  assign dat = host_dat_oe ? host_dat_o : (dev_dat_oe ? dev_dat_o : 1'b1);
  assign sdo = dev_sdo_oe ? dev_sdo_o : 1'b1;
  modport dev (input sclk, cs_n, dat, output dev_dat_o, dev_dat_oe, dev_sdo_o, dev_sdo_oe);
  modport host (input dat, sdo, output sclk, cs_n, host_dat_o, host_dat_oe);
endinterface
`default_nettype wire

// file: common/srp_pkg.sv
// Shared constants for the serial register port link
package srp_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] REG_PAGE = 8'h01;
  localparam logic [15:0] REG_WIRE_CFG = 16'h002B;
  localparam logic [15:0] REG_IO_SEL = 16'h0943;
  localparam int WIRE_BIT = 3;
  localparam int IO_BIT = 0;
  localparam logic [7:0] WIRE_CFG_RST = 8'h00;
  localparam logic [7:0] IO_SEL_RST = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  // ----------------------------------------
  // Host pll-change sequence values
  // ----------------------------------------
  localparam logic [15:0] PLL_SEQ_ADDR_A = 16'h0B24;
  localparam logic [15:0] PLL_SEQ_ADDR_B = 16'h0B25;
  localparam logic [7:0] PLL_PRE_A = 8'hD8;
  localparam logic [7:0] PLL_PRE_B = 8'h00;
  localparam logic [15:0] SOFT_RST_ADDR = 16'h001C;
  localparam logic [7:0] SOFT_RST_VAL = 8'h01;
  localparam logic [7:0] PLL_POST_A = 8'hDB;
  localparam logic [7:0] PLL_POST_B = 8'h02;
  localparam int PLL_WAIT_MS = 300;
  // ----------------------------------------
  // Serial protocol
  // ----------------------------------------
  localparam logic [4:0] I2C_ADDR_FIXED = 5'h0E;
  localparam logic [2:0] OP_SETA = 3'h0;
  localparam logic [2:0] OP_WR = 3'h2;
  localparam logic [2:0] OP_WRI = 3'h3;
  localparam logic [2:0] OP_RD = 3'h4;
  localparam logic [2:0] OP_RDI = 3'h5;
  localparam logic [7:0] OP_BURST = 8'hE0;
  localparam logic [7:0] INS_SETA = 8'h00;
  localparam logic [7:0] INS_WR = 8'h40;
  localparam logic [7:0] INS_RD = 8'h80;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;
  // ----------------------------------------
  // Host timing
  // ----------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int QUARTER_NS = 80;
  localparam logic [2:0] QUARTER_CYC = 3'((QUARTER_NS * CLK_MHZ) / 1000);
  // Host symbol kinds
  localparam logic [2:0] K_START = 3'h0;
  localparam logic [2:0] K_STOP = 3'h1;
  localparam logic [2:0] K_BYTE = 3'h2;
  localparam logic [2:0] K_READ = 3'h3;
  localparam logic [2:0] K_CSLO = 3'h4;
  localparam logic [2:0] K_CSHI = 3'h5;
  localparam logic [2:0] K_END = 3'h6;
endpackage

// file: design/srp_device.sv
// Serial register port, device end (I2C or SPI slave)
//
// Design decision made here: the write strobe register port (o_wr_stb, o_wr_addr, o_wr_data).
`timescale 1ns/1ps
`default_nettype none
module srp_device (
  input wire logic i_core_clk, // System clock
  input wire logic i_sys_rst, // Sync reset, high
  input wire logic i_i2c_sel, // Strap: 1 I2C, 0 SPI
  input wire logic [1:0] i_addr_sel, // I2C address select pins
  srp_link_if.dev lnk, // Serial pins
  output logic o_io_supply_sel, // Supply reference select
  output logic o_three_wire, // Three-wire select
  output logic o_wr_stb, // Register write pulse
  output logic [15:0] o_wr_addr, // Paged write address
  output logic [7:0] o_wr_data // Written byte
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [4:0] {
    I_IDLE = 5'b00001, I_ADR = 5'b00010, I_REG = 5'b00100, I_WR = 5'b01000, I_RD = 5'b10000
  } srp_i2c_st_t;
  typedef enum logic [7:0] {
    S_IDLE = 8'b00000001, S_INS = 8'b00000010, S_SETA = 8'b00000100, S_WR = 8'b00001000,
    S_RD = 8'b00010000, S_BADR = 8'b00100000, S_BDAT = 8'b01000000, S_IGN = 8'b10000000
  } srp_spi_st_t;
  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [2:0] dat_s;
    logic [1:0] sel_s;
    logic [3:0] asel_s;
    srp_i2c_st_t ist;
    srp_spi_st_t sst;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic [7:0] page;
    logic [7:0] wire_cfg;
    logic [7:0] io_sel;
    logic inc;
    logic dat_oe;
    logic dat_o;
    logic wr_stb;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
    logic [255:0][7:0] mem;
  } srp_dev_t;

  srp_dev_t r_reg;
  srp_dev_t r_next;

  // Paged register read
  function automatic logic [7:0] srp_rd(input srp_dev_t s, input logic [7:0] a);
    logic [7:0] v;
    v = s.mem[a];
    if (a == srp_pkg::REG_PAGE)
    begin
      v = s.page;
    end
    else if ({s.page, a} == srp_pkg::REG_WIRE_CFG)
    begin
      v = s.wire_cfg;
    end
    else if ({s.page, a} == srp_pkg::REG_IO_SEL)
    begin
      v = s.io_sel;
    end
    return v;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic rise;
    logic fall;
    logic din;
    logic start;
    logic stop;
    logic do_wr;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] b;
    logic [7:0] rv;
    rise = 1'b0;
    fall = 1'b0;
    din = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    do_wr = 1'b0;
    wa = 8'h00;
    wd = 8'h00;
    b = 8'h00;
    rv = 8'h00;
    r_next = r_reg;
    r_next.wr_stb = 1'b0;
    r_next.sclk_s = {r_reg.sclk_s[1:0], lnk.sclk};
    r_next.cs_s = {r_reg.cs_s[0], lnk.cs_n};
    r_next.dat_s = {r_reg.dat_s[1:0], lnk.dat};
    r_next.sel_s = {r_reg.sel_s[0], i_i2c_sel};
    r_next.asel_s = {r_reg.asel_s[1:0], i_addr_sel};
    rise = r_reg.sclk_s[1] & ~r_reg.sclk_s[2];
    fall = ~r_reg.sclk_s[1] & r_reg.sclk_s[2];
    din = r_reg.dat_s[1];
    if (rise)
    begin
      r_next.sr = {r_reg.sr[6:0], din};
    end
    b = {r_reg.sr[6:0], din};
    if (r_reg.sel_s[1])
    begin
      // ----------------------------------------
      // I2C slave
      // ----------------------------------------
      r_next.sst = S_IDLE;
      start = r_reg.sclk_s[1] & r_reg.sclk_s[2] & ~r_reg.dat_s[1] & r_reg.dat_s[2];
      stop = r_reg.sclk_s[1] & r_reg.sclk_s[2] & r_reg.dat_s[1] & ~r_reg.dat_s[2];
      if (rise && r_reg.cnt != srp_pkg::ACK_DONE)
      begin
        r_next.cnt = r_reg.cnt + 4'h1;
      end
      if (fall && r_reg.ist != I_IDLE)
      begin
        if (r_reg.cnt == srp_pkg::ACK_SLOT)
        begin
          case (r_reg.ist)
            I_ADR:
            begin
              if (r_reg.sr[7:1] == {srp_pkg::I2C_ADDR_FIXED, r_reg.asel_s[3:2]})
              begin
                r_next.dat_oe = 1'b1;
                r_next.ist = r_reg.sr[0] ? I_RD : I_REG;
              end
              else
              begin
                r_next.ist = I_IDLE;
              end
            end
            I_REG:
            begin
              r_next.ptr = r_reg.sr;
              r_next.dat_oe = 1'b1;
              r_next.ist = I_WR;
            end
            I_WR:
            begin
              do_wr = 1'b1;
              wa = r_reg.ptr;
              wd = r_reg.sr;
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.dat_oe = 1'b1;
            end
            default:
            begin
              r_next.dat_oe = 1'b0;
            end
          endcase
        end
        else if (r_reg.cnt == srp_pkg::ACK_DONE)
        begin
          r_next.cnt = 4'h0;
          r_next.dat_oe = 1'b0;
          if (r_reg.ist == I_RD)
          begin
            if (!r_reg.sr[0])
            begin
              rv = srp_rd(r_reg, r_reg.ptr);
              r_next.tx = rv;
              r_next.ptr = r_reg.ptr + 8'h01;
              r_next.dat_oe = ~rv[7];
            end
            else
            begin
              r_next.ist = I_IDLE;
            end
          end
        end
        else if (r_reg.ist == I_RD)
        begin
          r_next.dat_oe = ~r_reg.tx[3'(srp_pkg::BYTE_LAST - r_reg.cnt)];
        end
      end
      if (start)
      begin
        r_next.ist = I_ADR;
        r_next.cnt = 4'h0;
        r_next.dat_oe = 1'b0;
      end
      else if (stop)
      begin
        r_next.ist = I_IDLE;
        r_next.dat_oe = 1'b0;
      end
      r_next.dat_o = 1'b0;
    end
    else
    begin
      // ----------------------------------------
      // SPI slave, mode 0
      // ----------------------------------------
      r_next.ist = I_IDLE;
      if (r_reg.cs_s[1])
      begin
        r_next.sst = S_IDLE;
        r_next.cnt = 4'h0;
      end
      else if (r_reg.sst == S_IDLE)
      begin
        r_next.sst = S_INS;
        r_next.cnt = 4'h0;
      end
      else
      begin
        if (rise)
        begin
          r_next.cnt = r_reg.cnt + 4'h1;
          if (r_reg.cnt == srp_pkg::BYTE_LAST)
          begin
            r_next.cnt = 4'h0;
            case (r_reg.sst)
              S_INS:
              begin
                r_next.inc = b[5];
                case (b[7:5])
                  srp_pkg::OP_SETA: r_next.sst = S_SETA;
                  srp_pkg::OP_WR, srp_pkg::OP_WRI: r_next.sst = S_WR;
                  srp_pkg::OP_RD, srp_pkg::OP_RDI:
                  begin
                    r_next.sst = S_RD;
                    r_next.tx = srp_rd(r_reg, r_reg.ptr);
                  end
                  default: r_next.sst = (b == srp_pkg::OP_BURST) ? S_BADR : S_IGN;
                endcase
              end
              S_SETA:
              begin
                r_next.ptr = b;
                r_next.sst = S_INS;
              end
              S_WR:
              begin
                do_wr = 1'b1;
                wa = r_reg.ptr;
                wd = b;
                r_next.ptr = r_reg.inc ? r_reg.ptr + 8'h01 : r_reg.ptr;
                r_next.sst = S_INS;
              end
              S_RD:
              begin
                r_next.ptr = r_reg.inc ? r_reg.ptr + 8'h01 : r_reg.ptr;
                r_next.sst = S_INS;
              end
              S_BADR:
              begin
                r_next.ptr = b;
                r_next.sst = S_BDAT;
              end
              S_BDAT:
              begin
                do_wr = 1'b1;
                wa = r_reg.ptr;
                wd = b;
                r_next.ptr = r_reg.ptr + 8'h01;
              end
              default: r_next.sst = S_IGN;
            endcase
          end
        end
        if (fall && r_reg.sst == S_RD)
        begin
          r_next.dat_o = r_reg.tx[7];
          r_next.tx = {r_reg.tx[6:0], 1'b0};
        end
      end
      // Read drive: on with clock low, off at the fall after the byte
      r_next.dat_oe = ~r_reg.cs_s[1] & (((r_next.sst == S_RD)
        & (r_reg.dat_oe | (~r_reg.sclk_s[1] & ~r_reg.sclk_s[2])))
        | (r_reg.dat_oe & ~fall));
    end
    // ----------------------------------------
    // Register write
    // ----------------------------------------
    if (do_wr)
    begin
      r_next.wr_stb = 1'b1;
      r_next.wr_addr = {r_reg.page, wa};
      r_next.wr_data = wd;
      if (wa == srp_pkg::REG_PAGE)
      begin
        r_next.page = wd;
      end
      else if ({r_reg.page, wa} == srp_pkg::REG_WIRE_CFG)
      begin
        r_next.wire_cfg = wd;
      end
      else if ({r_reg.page, wa} == srp_pkg::REG_IO_SEL)
      begin
        r_next.io_sel = wd;
      end
      else
      begin
        r_next.mem[wa] = wd;
      end
    end
    if (i_sys_rst)
    begin
      r_next = '0;
      r_next.ist = I_IDLE;
      r_next.sst = S_IDLE;
      r_next.page = srp_pkg::PAGE_RST;
      r_next.wire_cfg = srp_pkg::WIRE_CFG_RST;
      r_next.io_sel = srp_pkg::IO_SEL_RST;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    r_reg <= r_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign lnk.dev_dat_o = r_reg.dat_o;
  assign lnk.dev_dat_oe = r_reg.dat_oe & (r_reg.sel_s[1] | r_reg.wire_cfg[srp_pkg::WIRE_BIT]);
  assign lnk.dev_sdo_o = r_reg.dat_o;
  assign lnk.dev_sdo_oe = r_reg.dat_oe & ~r_reg.sel_s[1]
    & ~r_reg.wire_cfg[srp_pkg::WIRE_BIT];
  assign o_io_supply_sel = r_reg.io_sel[srp_pkg::IO_BIT];
  assign o_three_wire = r_reg.wire_cfg[srp_pkg::WIRE_BIT];
  assign o_wr_stb = r_reg.wr_stb;
  assign o_wr_addr = r_reg.wr_addr;
  assign o_wr_data = r_reg.wr_data;
endmodule
`default_nettype wire

// file: design/srp_host.sv
// Serial register port, host end (I2C or SPI master)
`timescale 1ns/1ps
`default_nettype none
module srp_host (
  input wire logic i_core_clk, // System clock
  input wire logic i_sys_rst, // Sync reset, high
  input wire logic i_use_i2c, // 1 I2C, 0 SPI
  input wire logic i_three_wire, // Read on shared line
  input wire logic [1:0] i_dev_sel, // Device address pins
  input wire logic i_cmd_valid, // Command request
  input wire logic i_cmd_write, // 1 write, 0 read
  input wire logic [7:0] i_cmd_addr, // Register address in page
  input wire logic [7:0] i_cmd_wdata, // Write byte
  output logic o_cmd_ready, // Idle, takes command
  output logic o_rd_valid, // Read byte pulse
  output logic [7:0] o_rd_data, // Read byte
  output logic o_nack, // Last command saw a nack
  srp_link_if.host lnk // Serial pins
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {H_IDLE = 2'b01, H_RUN = 2'b10} srp_host_st_t;
  typedef struct packed {
    srp_host_st_t st;
    logic i2c;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [3:0] step;
    logic [3:0] bitn;
    logic [1:0] q;
    logic [2:0] qc;
    logic [7:0] rx;
    logic [1:0] dsel_s;
    logic [1:0] dat_s;
    logic [1:0] sdo_s;
    logic nack;
    logic scl;
    logic cs_n;
    logic dat_o;
    logic dat_oe;
    logic rd_valid;
    logic [7:0] rd_data;
  } srp_host_reg_t;

  srp_host_reg_t r_reg;
  srp_host_reg_t r_next;

  // Symbol list of one command
  function automatic logic [10:0] srp_seq(input srp_host_reg_t s, input logic [1:0] ds);
    logic [10:0] v;
    v = {srp_pkg::K_END, 8'h00};
    if (s.i2c)
    begin
      case (s.step)
        4'h0: v = {srp_pkg::K_START, 8'h00};
        4'h1: v = {srp_pkg::K_BYTE, srp_pkg::I2C_ADDR_FIXED, ds, 1'b0};
        4'h2: v = {srp_pkg::K_BYTE, s.addr};
        4'h3: v = s.wr ? {srp_pkg::K_BYTE, s.wdata} : {srp_pkg::K_START, 8'h00};
        4'h4: v = s.wr ? {srp_pkg::K_STOP, 8'h00}
          : {srp_pkg::K_BYTE, srp_pkg::I2C_ADDR_FIXED, ds, 1'b1};
        4'h5: v = s.wr ? {srp_pkg::K_END, 8'h00} : {srp_pkg::K_READ, 8'h00};
        4'h6: v = {srp_pkg::K_STOP, 8'h00};
        default: v = {srp_pkg::K_END, 8'h00};
      endcase
    end
    else
    begin
      case (s.step)
        4'h0: v = {srp_pkg::K_CSLO, 8'h00};
        4'h1: v = {srp_pkg::K_BYTE, srp_pkg::INS_SETA};
        4'h2: v = {srp_pkg::K_BYTE, s.addr};
        4'h3: v = {srp_pkg::K_BYTE, s.wr ? srp_pkg::INS_WR : srp_pkg::INS_RD};
        4'h4: v = s.wr ? {srp_pkg::K_BYTE, s.wdata} : {srp_pkg::K_READ, 8'h00};
        4'h5: v = {srp_pkg::K_CSHI, 8'h00};
        default: v = {srp_pkg::K_END, 8'h00};
      endcase
    end
    return v;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [2:0] kind;
    logic [7:0] byt;
    logic bitv;
    logic smp;
    logic [3:0] nbits;
    {kind, byt} = srp_seq(r_reg, r_reg.dsel_s);
    bitv = byt[3'(srp_pkg::BYTE_LAST - r_reg.bitn)];
    smp = (r_reg.i2c | i_three_wire) ? r_reg.dat_s[1] : r_reg.sdo_s[1];
    nbits = r_reg.i2c ? srp_pkg::ACK_DONE : srp_pkg::ACK_SLOT;
    r_next = r_reg;
    r_next.rd_valid = 1'b0;
    r_next.dsel_s = i_dev_sel;
    r_next.dat_s = {r_reg.dat_s[0], lnk.dat};
    r_next.sdo_s = {r_reg.sdo_s[0], lnk.sdo};
    case (r_reg.st)
      H_IDLE:
      begin
        r_next.scl = i_use_i2c;
        r_next.i2c = i_use_i2c;
        if (i_cmd_valid)
        begin
          r_next.st = H_RUN;
          r_next.wr = i_cmd_write;
          r_next.addr = i_cmd_addr;
          r_next.wdata = i_cmd_wdata;
          r_next.step = 4'h0;
          r_next.bitn = 4'h0;
          r_next.q = 2'h0;
          r_next.qc = 3'h0;
          r_next.nack = 1'b0;
          r_next.scl = 1'b0;
        end
      end
      H_RUN:
      begin
        r_next.qc = r_reg.qc + 3'h1;
        if (kind == srp_pkg::K_END)
        begin
          r_next.st = H_IDLE;
          r_next.rd_valid = ~r_reg.wr;
          r_next.rd_data = r_reg.rx;
        end
        else if (r_reg.qc == srp_pkg::QUARTER_CYC - 3'h1)
        begin
          r_next.qc = 3'h0;
          r_next.q = r_reg.q + 2'h1;
          case (r_reg.q)
            2'h0:
            begin
              if (kind == srp_pkg::K_CSLO || kind == srp_pkg::K_CSHI)
              begin
                r_next.cs_n = (kind == srp_pkg::K_CSHI);
              end
              else if (kind == srp_pkg::K_START)
              begin
                r_next.dat_oe = 1'b0;
              end
              else if (kind == srp_pkg::K_STOP)
              begin
                r_next.dat_oe = 1'b1;
                r_next.dat_o = 1'b0;
              end
              else if (kind == srp_pkg::K_BYTE && r_reg.bitn < srp_pkg::ACK_SLOT)
              begin
                r_next.dat_o = r_reg.i2c ? 1'b0 : bitv;
                r_next.dat_oe = r_reg.i2c ? ~bitv : 1'b1;
              end
              else
              begin
                r_next.dat_oe = 1'b0;
              end
            end
            2'h1:
            begin
              r_next.scl = (kind != srp_pkg::K_CSLO) && (kind != srp_pkg::K_CSHI);
              // Sample on the rising link clock edge
              if (r_reg.bitn < srp_pkg::ACK_SLOT && kind == srp_pkg::K_READ)
              begin
                r_next.rx = {r_reg.rx[6:0], smp};
              end
              if (r_reg.bitn == srp_pkg::ACK_SLOT && kind == srp_pkg::K_BYTE && smp)
              begin
                r_next.nack = 1'b1;
              end
            end
            2'h2:
            begin
              if (kind == srp_pkg::K_START)
              begin
                r_next.dat_oe = 1'b1;
                r_next.dat_o = 1'b0;
              end
              else if (kind == srp_pkg::K_STOP)
              begin
                r_next.dat_oe = 1'b0;
              end
            end
            default:
            begin
              r_next.bitn = 4'h0;
              r_next.step = r_reg.step + 4'h1;
              if (kind == srp_pkg::K_BYTE || kind == srp_pkg::K_READ)
              begin
                if (r_reg.bitn != nbits - 4'h1)
                begin
                  r_next.bitn = r_reg.bitn + 4'h1;
                  r_next.step = r_reg.step;
                end
              end
              if (kind != srp_pkg::K_STOP)
              begin
                r_next.scl = 1'b0;
              end
            end
          endcase
        end
      end
      default: r_next.st = H_IDLE;
    endcase
    if (i_sys_rst)
    begin
      r_next = '0;
      r_next.st = H_IDLE;
      r_next.cs_n = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    r_reg <= r_next;
  end

  assign o_cmd_ready = (r_reg.st == H_IDLE);
  assign o_rd_valid = r_reg.rd_valid;
  assign o_rd_data = r_reg.rd_data;
  assign o_nack = r_reg.nack;
  assign lnk.sclk = r_reg.scl;
  assign lnk.cs_n = r_reg.cs_n;
  assign lnk.host_dat_o = r_reg.dat_o;
  assign lnk.host_dat_oe = r_reg.dat_oe;
endmodule
`default_nettype wire

// file: test/srp_link_checker.sv
// Link protocol checks for the serial register port
`timescale 1ns/1ps
`default_nettype none
module srp_link_checker (
  input wire logic i_core_clk, // Clock
  input wire logic i_sys_rst, // Reset
  input wire logic sclk, // Link clock
  input wire logic cs_n, // Select
  input wire logic host_dat_o, // Host data
  input wire logic host_dat_oe, // Host enable
  input wire logic dev_dat_o, // Device data
  input wire logic dev_dat_oe, // Device enable
  input wire logic dev_sdo_o, // Device out
  input wire logic dev_sdo_oe, // Out enable
  input wire logic dat, // Shared line
  input wire logic sdo // Out line
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  logic sclk_reg;
  logic [7:0] rise_reg;
  // ----
  // Link clock rises per frame
  // ----
  always_ff @(posedge i_core_clk)
  begin
    sclk_reg <= sclk;
    if (i_sys_rst || cs_n)
      rise_reg <= 8'h00;
    else if (sclk && !sclk_reg)
      rise_reg <= rise_reg + 8'h01;
  end
  sequence start_s;
    cs_n && sclk && $fell(dat);
  endsequence
  sequence scl_low_s;
    ##[1:16] !sclk;
  endsequence
  // ----
  // Assertions
  // ----
  clk_gap_a: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("link clock edges too close");
  frame_open_a: assert property ($fell(cs_n) |-> !sclk)
    else $error("select fell with clock high");
  frame_bits_a: assert property ($rose(cs_n) |-> !sclk && rise_reg == 8'h20)
    else $error("frame not four whole bytes");
  spi_stable_a: assert property (!cs_n && !$past(cs_n) && sclk && $past(sclk)
    |-> $stable(dat) && $stable(sdo))
    else $error("data moved while clock high");
  sdo_window_a: assert property (dev_sdo_oe && !cs_n |-> rise_reg >= 8'h18)
    else $error("data out driven outside read byte");
  shared_turn_a: assert property (dev_dat_oe && !cs_n |-> rise_reg >= 8'h18 && !host_dat_oe)
    else $error("shared line driven outside read byte");
  drive_release_a: assert property ($rose(cs_n) |-> ##[0:6] !dev_sdo_oe && !dev_dat_oe)
    else $error("device drives after deselect");
  i2c_start_a: assert property (start_s |-> scl_low_s)
    else $error("clock did not fall after start");
  i2c_low_only_a: assert property (cs_n && $past(cs_n, 8) && dev_dat_oe |-> !dev_dat_o)
    else $error("device drove data line high");
endmodule
`default_nettype wire

// file: test/testbench.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_core_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i2c_sel = 1'b0;
  logic use_i2c = 1'b0;
  logic three_wire = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [1:0] addr_sel = 2'h0;
  logic [1:0] dev_sel = 2'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic ready, rd_valid, nack, io_sel, three_w, wr_stb;
  logic [7:0] rd_data, wr_data, last_data;
  logic [15:0] wr_addr, last_addr;
  int err_total = 0;
  int n_compared = 0;
  srp_link_if lnk ();
  srp_device srp_device_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_i2c_sel(i2c_sel),
    .i_addr_sel(addr_sel), .lnk(lnk.dev), .o_io_supply_sel(io_sel), .o_three_wire(three_w),
    .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  srp_host srp_host_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_use_i2c(use_i2c),
    .i_three_wire(three_wire), .i_dev_sel(dev_sel), .i_cmd_valid(cmd_valid),
    .i_cmd_write(cmd_write), .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata), .o_cmd_ready(ready),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_nack(nack), .lnk(lnk.host));
  srp_link_checker srp_link_checker_inst (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .sclk(lnk.sclk), .cs_n(lnk.cs_n), .host_dat_o(lnk.host_dat_o), .host_dat_oe(lnk.host_dat_oe),
    .dev_dat_o(lnk.dev_dat_o), .dev_dat_oe(lnk.dev_dat_oe), .dev_sdo_o(lnk.dev_sdo_o),
    .dev_sdo_oe(lnk.dev_sdo_oe), .dat(lnk.dat), .sdo(lnk.sdo));
  always #10 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk)
  begin
    if (wr_stb === 1'b1)
    begin
      last_addr <= wr_addr;
      last_data <= wr_data;
    end
  end
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge i_core_clk);
    while (ready !== 1'b1 && n < 3000)
    begin
      @(negedge i_core_clk);
      n++;
    end
    chk({15'h0, ready}, 16'h1, "command done");
  endtask
  task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
    wait_ready();
    @(posedge i_core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge i_core_clk);
    cmd_valid <= 1'b0;
    wait_ready();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cmd(1'b1, a[7:0], d);
    chk(last_addr, a, "write address");
    chk({8'h00, last_data}, {8'h00, d}, "write data");
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cmd(1'b0, a, 8'h00);
    chk({15'h0, rd_valid}, 16'h1, "read strobe");
    chk({8'h00, rd_data}, {8'h00, e}, "read data");
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    chk({15'h0, io_sel}, 16'h0, "supply select reset");
    chk({15'h0, three_w}, 16'h0, "three wire reset");
    $display("test reset done");
  endtask
  task automatic t_spi();
    wr(16'h0010, 8'h5A);
    rd(8'h10, 8'h5A);
    wr(16'h00FF, 8'hA5);
    rd(8'hFF, 8'hA5);
    wr(16'h002B, 8'h08);
    chk({15'h0, three_w}, 16'h1, "three wire set");
    @(posedge i_core_clk);
    three_wire <= 1'b1;
    wr(16'h0011, 8'h3C);
    rd(8'h11, 8'h3C);
    wr(16'h0001, 8'h09);
    wr(16'h0943, 8'h01);
    chk({15'h0, io_sel}, 16'h1, "supply select set");
    wr(16'h0901, 8'h00);
    $display("test spi done");
  endtask
  task automatic t_i2c();
    @(posedge i_core_clk);
    i2c_sel <= 1'b1;
    use_i2c <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_core_clk);
      addr_sel <= 2'(k);
      dev_sel <= 2'(k);
      repeat (8) @(posedge i_core_clk);
      wr({8'h00, 8'h20 + 8'(k)}, 8'hC3 ^ 8'(k));
      chk({15'h0, nack}, 16'h0, "address ack");
      rd(8'h20 + 8'(k), 8'hC3 ^ 8'(k));
      @(posedge i_core_clk);
      dev_sel <= ~2'(k);
      cmd(1'b1, 8'h20, 8'h00);
      chk({15'h0, nack}, 16'h1, "foreign address");
      chk({8'h00, last_data}, {8'h00, 8'hC3 ^ 8'(k)}, "no stray write");
    end
    $display("test i2c done");
  endtask
  task automatic test_done();
    $display("Counts: compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    t_reset();
    t_spi();
    t_i2c();
    test_done();
  end
  initial
  begin
    #1000000;
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
